// ==== rtl/peirq_params.svh ====
`ifndef PEIRQ_PARAMS_SVH
`define PEIRQ_PARAMS_SVH

// ==========================================================
// Register byte addresses
`define PEIRQ_ADDR_RISE 32'h4004c01c
`define PEIRQ_ADDR_FALL 32'h4004c020
`define PEIRQ_ADDR_STAT 32'h4004c024
`define PEIRQ_ADDR_MODE 32'h4004c030
`define PEIRQ_ADDR_ENR 32'h4004c034
`define PEIRQ_ADDR_ENF 32'h4004c038
`define PEIRQ_ADDR_MASK 32'h4004c03c

// ==========================================================
// Field layout and reset values
`define PEIRQ_CHANS 8
`define PEIRQ_FLAG_LSB 0
`define PEIRQ_FLAGS_RST 8'h00
`define PEIRQ_CFG_RST 8'h00
`define PEIRQ_MASK_RST 8'h00
`define PEIRQ_RDATA_RST 32'h0000_0000
`define PEIRQ_RDATA_PAD 24'h00_0000
`define PEIRQ_HTRANS_ACTIVE_BIT 1
`define PEIRQ_HRESP_OKAY 1'b0

`endif

// ==== rtl/peirq_pkg.sv ====
`include "peirq_params.svh"

package peirq_pkg;

	typedef logic [`PEIRQ_CHANS-1:0] peirq_chan_type;

	// Per-channel configuration kept by software.
	typedef struct packed {
		peirq_chan_type sense_kind;
		peirq_chan_type rise_or_level_enable;
		peirq_chan_type fall_enable_or_polarity;
	} peirq_cfg_type;

	// Address phase captured for the following data phase.
	typedef struct packed {
		logic [31:0] addr;
		logic write;
	} peirq_bus_cmd_type;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_WRITE,
		PH_READ
	} peirq_phase_type;

endpackage

// ==== rtl/peirq_top.sv ====
// Added by the designer: the AHB-Lite register port.
`include "peirq_params.svh"

module peirq_top (
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic [`PEIRQ_CHANS-1:0] PIN_IN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic IRQ,
	output logic [`PEIRQ_CHANS-1:0] CHAN_REQ
);

	// ==========================================================
	// Storage

	logic [`PEIRQ_CHANS-1:0] pin_r;
	logic [`PEIRQ_CHANS-1:0] pin_d_r;
	logic armed_r;
	logic [`PEIRQ_CHANS-1:0] rise_r;
	logic [`PEIRQ_CHANS-1:0] fall_r;
	logic [`PEIRQ_CHANS-1:0] mask_r;
	logic [`PEIRQ_CHANS-1:0] req_r;
	logic [31:0] hrdata_r;
	logic hreadyout_r;
	logic hresp_r;
	logic irq_r;
	peirq_pkg::peirq_cfg_type cfg_r;
	peirq_pkg::peirq_bus_cmd_type cmd_r;
	peirq_pkg::peirq_phase_type phase_r;

	// ==========================================================
	// Bus decode

	// HSIZE is not checked: only whole-word transfers reach this slave.
	wire addr_take;
	wire wr_now;
	wire rd_now;
	wire hit_rise;
	wire hit_fall;
	wire hit_stat;
	wire hit_mode;
	wire hit_enr;
	wire hit_enf;
	wire hit_mask;
	wire [`PEIRQ_CHANS-1:0] wdata8;

	assign addr_take = HSEL & HREADY & HTRANS[`PEIRQ_HTRANS_ACTIVE_BIT];
	assign wr_now = (phase_r == peirq_pkg::PH_WRITE);
	assign rd_now = (phase_r == peirq_pkg::PH_READ);
	assign hit_rise = (cmd_r.addr == `PEIRQ_ADDR_RISE);
	assign hit_fall = (cmd_r.addr == `PEIRQ_ADDR_FALL);
	assign hit_stat = (cmd_r.addr == `PEIRQ_ADDR_STAT);
	assign hit_mode = (cmd_r.addr == `PEIRQ_ADDR_MODE);
	assign hit_enr = (cmd_r.addr == `PEIRQ_ADDR_ENR);
	assign hit_enf = (cmd_r.addr == `PEIRQ_ADDR_ENF);
	assign hit_mask = (cmd_r.addr == `PEIRQ_ADDR_MASK);
	assign wdata8 = HWDATA[`PEIRQ_CHANS-1:`PEIRQ_FLAG_LSB];

	wire wr_rise = wr_now & hit_rise;
	wire wr_fall = wr_now & hit_fall;
	wire wr_stat = wr_now & hit_stat;

	peirq_pkg::peirq_phase_type phase_nxt;
	assign phase_nxt = !addr_take ? peirq_pkg::PH_IDLE :
		(HWRITE ? peirq_pkg::PH_WRITE : peirq_pkg::PH_READ);

	// Reads insert one wait state so that a write in the previous data phase
	// is always visible; writes complete with no wait.
	wire hreadyout_nxt = !(addr_take & !HWRITE);

	// ==========================================================
	// Edge detection

	// The first sample after reset only primes the history, so a pin that is
	// already high is not mistaken for a rising edge.
	wire [`PEIRQ_CHANS-1:0] rise_evt;
	wire [`PEIRQ_CHANS-1:0] fall_evt;
	assign rise_evt = armed_r ? (pin_r & ~pin_d_r) : `PEIRQ_FLAGS_RST;
	assign fall_evt = armed_r ? (~pin_r & pin_d_r) : `PEIRQ_FLAGS_RST;

	wire [`PEIRQ_CHANS-1:0] mode;
	wire [`PEIRQ_CHANS-1:0] enr;
	wire [`PEIRQ_CHANS-1:0] enf;
	assign mode = cfg_r.sense_kind;
	assign enr = cfg_r.rise_or_level_enable;
	assign enf = cfg_r.fall_enable_or_polarity;

	// A status write clears the edge channels and flips the active level of the level channels whose bits it writes as ones.
	wire [`PEIRQ_CHANS-1:0] stat_edge_clr;
	assign stat_edge_clr = wr_stat ? (wdata8 & ~mode) : `PEIRQ_FLAGS_RST;

	wire [`PEIRQ_CHANS-1:0] rise_clr;
	wire [`PEIRQ_CHANS-1:0] fall_clr;
	assign rise_clr = (wr_rise ? wdata8 : `PEIRQ_FLAGS_RST) | stat_edge_clr;
	assign fall_clr = (wr_fall ? wdata8 : `PEIRQ_FLAGS_RST) | stat_edge_clr;

	// A new edge in the clearing cycle wins, so no event is lost.
	wire [`PEIRQ_CHANS-1:0] rise_nxt;
	wire [`PEIRQ_CHANS-1:0] fall_nxt;
	assign rise_nxt = (rise_r & ~rise_clr) | rise_evt;
	assign fall_nxt = (fall_r & ~fall_clr) | fall_evt;

	// ==========================================================
	// Configuration

	peirq_pkg::peirq_cfg_type cfg_nxt;
	assign cfg_nxt.sense_kind = (wr_now & hit_mode) ? wdata8 : mode;
	assign cfg_nxt.rise_or_level_enable = (wr_now & hit_enr) ? wdata8 : enr;
	assign cfg_nxt.fall_enable_or_polarity = (wr_now & hit_enf) ? wdata8 :
		(wr_stat ? (enf ^ (wdata8 & mode)) : enf);

	wire [`PEIRQ_CHANS-1:0] mask_nxt;
	assign mask_nxt = (wr_now & hit_mask) ? wdata8 : mask_r;

	// ==========================================================
	// Request generation

	wire [`PEIRQ_CHANS-1:0] edge_req;
	wire [`PEIRQ_CHANS-1:0] level_req;
	wire [`PEIRQ_CHANS-1:0] req_now;
	assign edge_req = ~mode & ((rise_r & enr) | (fall_r & enf));
	assign level_req = mode & enr & ~(pin_r ^ enf);
	assign req_now = edge_req | level_req;

	wire irq_nxt = |(req_now & mask_r);

	// ==========================================================
	// Read data

	wire [`PEIRQ_CHANS-1:0] rd_sel;
	assign rd_sel = hit_rise ? rise_r :
		hit_fall ? fall_r :
		hit_stat ? req_now :
		hit_mode ? mode :
		hit_enr ? enr :
		hit_enf ? enf :
		hit_mask ? mask_r :
		`PEIRQ_FLAGS_RST;

	wire [31:0] hrdata_nxt;
	assign hrdata_nxt = rd_now ? {`PEIRQ_RDATA_PAD, rd_sel} : hrdata_r;

	// ==========================================================
	// Flip-flops

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			pin_r <= `PEIRQ_FLAGS_RST;
			pin_d_r <= `PEIRQ_FLAGS_RST;
			armed_r <= 1'b0;
		end else begin
			pin_r <= PIN_IN;
			// Until armed, the history takes the pin itself, so a level held across reset is no edge.
			pin_d_r <= armed_r ? pin_r : PIN_IN;
			armed_r <= 1'b1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			rise_r <= `PEIRQ_FLAGS_RST;
			fall_r <= `PEIRQ_FLAGS_RST;
			req_r <= `PEIRQ_FLAGS_RST;
			irq_r <= 1'b0;
		end else begin
			rise_r <= rise_nxt;
			fall_r <= fall_nxt;
			req_r <= req_now;
			irq_r <= irq_nxt;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			cfg_r <= {`PEIRQ_CFG_RST, `PEIRQ_CFG_RST, `PEIRQ_CFG_RST};
			mask_r <= `PEIRQ_MASK_RST;
		end else begin
			cfg_r <= cfg_nxt;
			mask_r <= mask_nxt;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			phase_r <= peirq_pkg::PH_IDLE;
			cmd_r <= '0;
			hrdata_r <= `PEIRQ_RDATA_RST;
			hreadyout_r <= 1'b1;
			hresp_r <= `PEIRQ_HRESP_OKAY;
		end else begin
			phase_r <= phase_nxt;
			if (addr_take) begin
				cmd_r <= '{addr: HADDR, write: HWRITE};
			end
			hrdata_r <= hrdata_nxt;
			hreadyout_r <= hreadyout_nxt;
			hresp_r <= `PEIRQ_HRESP_OKAY;
		end
	end

	assign HRDATA = hrdata_r;
	assign HREADYOUT = hreadyout_r;
	assign HRESP = hresp_r;
	assign IRQ = irq_r;
	assign CHAN_REQ = req_r;

	// ==========================================================
	// Checks

	property p_rise_set;
		@(posedge REF_CLK) disable iff (!RST_B)
		|rise_evt |=> ((rise_r & $past(rise_evt)) == $past(rise_evt));
	endproperty
	a_rise_set: assert property (p_rise_set)
		else $error("rising edge did not set its flag");

	property p_capture_disabled;
		@(posedge REF_CLK) disable iff (!RST_B)
		(|(fall_evt & ~enf)) |=> ((fall_r & $past(fall_evt & ~enf)) == $past(fall_evt & ~enf));
	endproperty
	a_capture_disabled: assert property (p_capture_disabled)
		else $error("falling edge lost while its enable was off");

	property p_rise_w1c;
		@(posedge REF_CLK) disable iff (!RST_B)
		(wr_rise && !(|rise_evt) && !wr_stat) |=>
			(rise_r == ($past(rise_r) & ~$past(wdata8)));
	endproperty
	a_rise_w1c: assert property (p_rise_w1c)
		else $error("rise flag write did not clear exactly the ones");

	property p_fall_set;
		@(posedge REF_CLK) disable iff (!RST_B)
		|fall_evt |=> ((fall_r & $past(fall_evt)) == $past(fall_evt));
	endproperty
	a_fall_set: assert property (p_fall_set)
		else $error("falling edge did not set its flag");

	property p_fall_w1c;
		@(posedge REF_CLK) disable iff (!RST_B)
		(wr_fall && !(|fall_evt)) |=>
			(fall_r == ($past(fall_r) & ~$past(wdata8)));
	endproperty
	a_fall_w1c: assert property (p_fall_w1c)
		else $error("fall flag write did not clear exactly the ones");

	property p_edge_gate;
		@(posedge REF_CLK) disable iff (!RST_B)
		##1 ((CHAN_REQ & $past(~mode) & ~$past((rise_r & enr) | (fall_r & enf))) == '0);
	endproperty
	a_edge_gate: assert property (p_edge_gate)
		else $error("edge request without an enabled flag");

	property p_stat_clear;
		@(posedge REF_CLK) disable iff (!RST_B)
		(wr_stat && !(|rise_evt) && !(|fall_evt)) |=>
			(((rise_r | fall_r) & $past(wdata8 & ~mode)) == '0);
	endproperty
	a_stat_clear: assert property (p_stat_clear)
		else $error("status write did not clear edge flags");

	property p_level_flip;
		@(posedge REF_CLK) disable iff (!RST_B)
		wr_stat |=> (enf == ($past(enf) ^ ($past(wdata8) & $past(mode))));
	endproperty
	a_level_flip: assert property (p_level_flip)
		else $error("status write did not flip the active level");

	property p_level_req;
		@(posedge REF_CLK) disable iff (!RST_B)
		##1 ((CHAN_REQ & $past(mode)) == $past(mode & enr & ~(pin_r ^ enf)));
	endproperty
	a_level_req: assert property (p_level_req)
		else $error("level request does not follow the pin");

	sequence s_read_stat;
		addr_take && !HWRITE && (HADDR == `PEIRQ_ADDR_STAT) ##1 !HREADYOUT ##1 HREADYOUT;
	endsequence

	property p_read_stat;
		@(posedge REF_CLK) disable iff (!RST_B)
		s_read_stat |-> (HRDATA == {`PEIRQ_RDATA_PAD, $past(req_now)});
	endproperty
	a_read_stat: assert property (p_read_stat)
		else $error("status read does not show the request");

	property p_irq_mask;
		@(posedge REF_CLK) disable iff (!RST_B)
		(mask_r == '0) ##1 (mask_r == '0) |-> !IRQ;
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("interrupt raised with every channel masked");

endmodule

// ==== sim/peirq_tb.sv ====
`include "peirq_params.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Stimulus signals and reference model state.
	logic REF_CLK;
	logic RST_B;
	logic [7:0] PIN_IN;
	logic HSEL;
	logic [31:0] HADDR;
	logic [1:0] HTRANS;
	logic HWRITE;
	logic [2:0] HSIZE;
	logic [31:0] HWDATA;
	wire logic HREADY;
	logic [31:0] HRDATA;
	logic HREADYOUT;
	logic HRESP;
	logic IRQ;
	logic [7:0] CHAN_REQ;
	int errors;
	int total_checks;
	logic [7:0] m_rise, m_fall, m_mode, m_enr, m_enf, m_mask, m_pin;
	logic [31:0] rd;
	logic [31:0] d;
	int i;

	// The single slave's ready output is the bus ready.
	assign HREADY = HREADYOUT;

	peirq_top dut (
		.REF_CLK(REF_CLK),
		.RST_B(RST_B),
		.PIN_IN(PIN_IN),
		.HSEL(HSEL),
		.HADDR(HADDR),
		.HTRANS(HTRANS),
		.HWRITE(HWRITE),
		.HSIZE(HSIZE),
		.HWDATA(HWDATA),
		.HREADY(HREADY),
		.HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT),
		.HRESP(HRESP),
		.IRQ(IRQ),
		.CHAN_REQ(CHAN_REQ)
	);

	initial begin
		REF_CLK = 1'b0;
		forever #50 REF_CLK = ~REF_CLK;
	end

	// ==========================================================
	// Reporting.
	task automatic finish_test();
		$display("Checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Level channels follow the live pin; edge channels follow the sticky flags.
	function automatic logic [7:0] req();
		return (~m_mode & ((m_rise & m_enr) | (m_fall & m_enf))) | (m_mode & m_enr & ~(m_pin ^ m_enf));
	endfunction

	// ==========================================================
	// Bus access, entered just after a rising edge.
	task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] dat, output logic [31:0] q);
		int n;
		n = 0;
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= wr;
		HSIZE <= 3'h2;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (HREADY !== 1'b1 && n < 50);
		// An address phase that is never accepted counts as a timeout below.
		if (HREADY !== 1'b1) begin
			n = 100;
		end
		HTRANS <= 2'h0;
		HSEL <= 1'b0;
		HWDATA <= dat;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (HREADY !== 1'b1 && n < 100);
		q = HRDATA;
		chk({31'h0, HRESP}, 32'h0);
		if (n >= 100) begin
			errors++;
			finish_test();
		end
	endtask

	task automatic check_all();
		logic [31:0] q;
		repeat (4) @(posedge REF_CLK);
		chk({24'h0, CHAN_REQ}, {24'h0, req()});
		chk({31'h0, IRQ}, {31'h0, |(req() & m_mask)});
		bus(`PEIRQ_ADDR_RISE, 1'b0, 32'h0, q);
		chk(q, {24'h0, m_rise});
		bus(`PEIRQ_ADDR_FALL, 1'b0, 32'h0, q);
		chk(q, {24'h0, m_fall});
		bus(`PEIRQ_ADDR_STAT, 1'b0, 32'h0, q);
		chk(q, {24'h0, req()});
		bus(`PEIRQ_ADDR_ENF, 1'b0, 32'h0, q);
		chk(q, {24'h0, m_enf});
		bus(`PEIRQ_ADDR_MODE, 1'b0, 32'h0, q);
		chk(q, {24'h0, m_mode});
		bus(`PEIRQ_ADDR_ENR, 1'b0, 32'h0, q);
		chk(q, {24'h0, m_enr});
		bus(`PEIRQ_ADDR_MASK, 1'b0, 32'h0, q);
		chk(q, {24'h0, m_mask});
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		RST_B = 1'b0;
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h0;
		PIN_IN = 8'h00;
		{m_rise, m_fall, m_mode, m_enr, m_enf, m_mask, m_pin} = 56'h0;
		errors = 0;
		total_checks = 0;
		void'($urandom(32'ha129));
		repeat (20) @(posedge REF_CLK);
		RST_B <= 1'b1;
		// Edge detection is armed on the first edge after release, well inside this wait.
		repeat (4) @(posedge REF_CLK);
		check_all();
		bus(32'h4004c040, 1'b1, 32'hff, rd);
		bus(32'h4004c040, 1'b0, 32'h0, rd);
		chk(rd, 32'h0);
		for (i = 0; i < 80; i++) begin
			d = $urandom;
			if (i % 8 == 0) begin
				m_mode = d[7:0];
				m_enr = d[15:8];
				m_enf = d[23:16];
				m_mask = d[31:24];
				bus(`PEIRQ_ADDR_MODE, 1'b1, {24'h0, m_mode}, rd);
				bus(`PEIRQ_ADDR_ENR, 1'b1, {24'h0, m_enr}, rd);
				bus(`PEIRQ_ADDR_ENF, 1'b1, {24'h0, m_enf}, rd);
				bus(`PEIRQ_ADDR_MASK, 1'b1, {24'h0, m_mask}, rd);
			end else begin
				case (d[9:8])
					2'h0, 2'h1: begin
						PIN_IN <= d[7:0];
						m_rise = m_rise | (d[7:0] & ~m_pin);
						m_fall = m_fall | (~d[7:0] & m_pin);
						m_pin = d[7:0];
					end
					2'h2: begin
						bus(d[10] ? `PEIRQ_ADDR_RISE : `PEIRQ_ADDR_FALL, 1'b1, d, rd);
						if (d[10]) m_rise = m_rise & ~d[7:0];
						else m_fall = m_fall & ~d[7:0];
					end
					default: begin
						bus(`PEIRQ_ADDR_STAT, 1'b1, d, rd);
						m_rise = m_rise & ~(d[7:0] & ~m_mode);
						m_fall = m_fall & ~(d[7:0] & ~m_mode);
						m_enf = m_enf ^ (d[7:0] & m_mode);
					end
				endcase
			end
			check_all();
		end
		// A reset in mid-run with every pin high must leave no flag and raise no false edge.
		PIN_IN <= 8'hff;
		RST_B <= 1'b0;
		repeat (3) @(posedge REF_CLK);
		RST_B <= 1'b1;
		{m_rise, m_fall, m_mode, m_enr, m_enf, m_mask} = 48'h0;
		m_pin = 8'hff;
		check_all();
		finish_test();
	end
endmodule
